/* File: verilog/ldc_pkg.sv */
package ldc_pkg;

    // Register word indices; byte address is four times the index
    localparam int         LDC_ADDR_W       = 10;
    localparam logic [7:0] LDC_OFF_TRIM     = 8'h68;
    localparam logic [7:0] LDC_OFF_GAINFILT = 8'h69;
    localparam logic [7:0] LDC_OFF_TEMPPL   = 8'h6a;
    localparam logic [7:0] LDC_OFF_DIVHI    = 8'h6b;
    localparam logic [7:0] LDC_OFF_SYNC     = 8'h6c;

    // Word index of each register in the bank
    localparam int LDC_NREG     = 5;
    localparam int LDC_IDX_TRIM = 0;
    localparam int LDC_IDX_GF   = 1;
    localparam int LDC_IDX_TP   = 2;
    localparam int LDC_IDX_DH   = 3;
    localparam int LDC_IDX_SY   = 4;

    // Reset values
    localparam logic [7:0] LDC_RST_TRIM     = 8'h77;
    localparam logic [7:0] LDC_RST_GAINFILT = 8'h00;
    localparam logic [7:0] LDC_RST_TEMPPL   = 8'h00;
    localparam logic [7:0] LDC_RST_DIVHI    = 8'h00;
    localparam logic [7:0] LDC_RST_SYNC     = 8'h00;

    // Field positions
    localparam int LDC_POS_HI_NIB  = 4;
    localparam int LDC_POS_TDIM_EN = 7;
    localparam int LDC_POS_NTYPE   = 6;
    localparam int LDC_POS_SOFT    = 4;
    localparam int LDC_POS_LIMIT   = 2;
    localparam int LDC_POS_GATE    = 0;
    localparam int LDC_POS_SYNC_EN = 7;
    localparam int LDC_POS_LOCK    = 6;
    localparam int LDC_POS_CRST    = 5;
    localparam int LDC_DIV_LO_W    = 5;

    // Soft-start times in ms, and cycle counts at 100 MHz
    localparam int LDC_CLK_MHZ = 100;
    localparam int LDC_SS0_MS  = 5;
    localparam int LDC_SS1_MS  = 10;
    localparam int LDC_SS2_MS  = 20;
    localparam int LDC_SS3_MS  = 50;
    localparam int LDC_SS0_CYC = LDC_SS0_MS * 1000 * LDC_CLK_MHZ;
    localparam int LDC_SS1_CYC = LDC_SS1_MS * 1000 * LDC_CLK_MHZ;
    localparam int LDC_SS2_CYC = LDC_SS2_MS * 1000 * LDC_CLK_MHZ;
    localparam int LDC_SS3_CYC = LDC_SS3_MS * 1000 * LDC_CLK_MHZ;

endpackage

/* File: verilog/ldc_reg8.sv */
// One 8-bit configuration register with write strobe
module ldc_reg8
    import ldc_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Write side
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    // Stored value
    output logic      [7:0] q
);

    typedef struct packed {
        logic [7:0] value;
    } ldc_reg8_t;

    ldc_reg8_t st;
    ldc_reg8_t next_st;

    always_comb begin
        next_st = st;
        if (wr) begin
            next_st.value = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.value <= RESET_VALUE;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign q = st.value;

endmodule

/* File: verilog/ldc_config_bank.sv */
// Behaviour
// - Bits 7:4 trim sink four current
// - Bits 3:0 trim sink three current
// - Bits 7:4 set temperature dimming gain
// - Comparator must hold selected PWM-clock count
// - Bits 5:4 at 0x6A pick soft-start
// - Divider bits 12:5 from upper register
// - Divider bits 4:0 from 0x6C
// - Bit 7 at 0x6C gates frame sync
// - Bit 6 locks PWM to frame sync
// - Bit 5 restarts PWM counter on edge
// - PLL off: PWM clock from oscillator
// - Slow divider used for frame sync; code selects it only while PLL is on and bit 6 is set
//
// The APB interface to the registers was chosen for this implementation.
module ldc_config_bank
    import ldc_pkg::*;
#(
    parameter int DIV_W = 13,
    parameter int NIB_W = 4
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [LDC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Frame sync and PWM status from the PWM generator
    input  wire logic             frame_sync_in,
    input  wire logic             pll_enable,
    input  wire logic             pwm_tick,
    input  wire logic             headroom_cmp,
    // Trim and dimming fields
    output logic [NIB_W-1:0]      sink_four_current_trim,
    output logic [NIB_W-1:0]      sink_three_current_trim,
    output logic [NIB_W-1:0]      temp_sensor_dim_gain,
    output logic                  temp_current_dim_enable,
    // Power-line switch fields
    output logic                  powerline_switch_n_type,
    output logic [1:0]            powerline_current_limit_sel,
    output logic [1:0]            powerline_gate_current_sel,
    output logic                  soft_start_done,
    // Sync and PLL control
    output logic [DIV_W-1:0]      slow_divider,
    output logic                  frame_sync_gated,
    output logic                  pwm_lock_enable,
    output logic                  pwm_counter_restart,
    output logic                  pwm_clk_from_osc,
    output logic                  use_slow_divider,
    output logic                  headroom_cmp_valid
);

    // Field packing is fixed to the documented widths
    if (DIV_W != 13 || NIB_W != 4) begin : g_bad_width
        $error("ldc_config_bank: only DIV_W=13, NIB_W=4 supported");
    end

    // Register bank
    logic [7:0] regs  [LDC_NREG];
    logic [7:0] wr_sel;
    logic       acc;
    logic       hit;
    int         idx;

    localparam logic [7:0] RSTV [LDC_NREG] = '{LDC_RST_TRIM,
        LDC_RST_GAINFILT, LDC_RST_TEMPPL, LDC_RST_DIVHI, LDC_RST_SYNC};

    assign acc = psel && penable;

    always_comb begin
        idx = 0;
        // Word aligned only: a byte lane offset is refused
        hit = (paddr[1:0] == 2'b00);
        unique case (paddr[LDC_ADDR_W-1:2])
            LDC_OFF_TRIM:     idx = LDC_IDX_TRIM;
            LDC_OFF_GAINFILT: idx = LDC_IDX_GF;
            LDC_OFF_TEMPPL:   idx = LDC_IDX_TP;
            LDC_OFF_DIVHI:    idx = LDC_IDX_DH;
            LDC_OFF_SYNC:     idx = LDC_IDX_SY;
            default:          hit = 1'b0;
        endcase
        wr_sel = 8'h00;
        if (acc && pwrite && hit) begin
            wr_sel[idx] = 1'b1;
        end
    end

    for (genvar g = 0; g < LDC_NREG; g++) begin : g_reg
        ldc_reg8 #(
            .RESET_VALUE (RSTV[g])
        ) u_reg (
            .clk   (clk),
            .rst_n (rst_n),
            .ce    (ce),
            .wr    (wr_sel[g]),
            .wdata (pwdata[7:0]),
            .q     (regs[g])
        );
    end

    // Filter length lookup, in PWM clock cycles
    function automatic logic [8:0] filt_len(input logic [3:0] code);
        logic [8:0] n;
        n = 9'h000;
        unique case (code)
            4'h0: n = 9'd5;
            4'h1: n = 9'd10;
            4'h2: n = 9'd20;
            4'h3: n = 9'd40;
            4'h4: n = 9'd60;
            4'h5: n = 9'd80;
            4'h6: n = 9'd100;
            default: n = 9'(140 + 40 * (int'(code) - 7));
        endcase
        return n;
    endfunction

    function automatic logic [31:0] ss_len(input logic [1:0] code);
        logic [31:0] n;
        n = 32'h0;
        unique case (code)
            2'b00: n = 32'(LDC_SS0_CYC);
            2'b01: n = 32'(LDC_SS1_CYC);
            2'b10: n = 32'(LDC_SS2_CYC);
            2'b11: n = 32'(LDC_SS3_CYC);
        endcase
        return n;
    endfunction

    typedef struct packed {
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic [8:0]       filt_cnt;
        logic             cmp_valid;
        logic [31:0]      ss_cnt;
        logic             ss_done;
        logic             fs_prev;
        logic             fs_gated;
        logic             crst;
        logic [3:0]       trim4;
        logic [3:0]       trim3;
        logic [3:0]       gain;
        logic             tdim;
        logic             ntype;
        logic [1:0]       limit;
        logic [1:0]       gate;
        logic [DIV_W-1:0] div;
        logic             lock;
        logic             osc;
        logic             slow;
    } ldc_state_t;

    ldc_state_t st;
    ldc_state_t next_st;

    always_comb begin
        next_st = st;
        // Zero-wait APB: answer in the first access cycle
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && !penable) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = !hit;
            next_st.prdata  = 32'h0;
            if (!pwrite && hit) begin
                next_st.prdata = {24'h0, regs[idx]};
            end
        end
        next_st.trim4 = regs[LDC_IDX_TRIM][7:LDC_POS_HI_NIB];
        next_st.trim3 = regs[LDC_IDX_TRIM][LDC_POS_HI_NIB-1:0];
        next_st.gain  = regs[LDC_IDX_GF][7:LDC_POS_HI_NIB];
        next_st.tdim  = regs[LDC_IDX_TP][LDC_POS_TDIM_EN];
        next_st.ntype = regs[LDC_IDX_TP][LDC_POS_NTYPE];
        next_st.limit = regs[LDC_IDX_TP][LDC_POS_LIMIT +: 2];
        next_st.gate  = regs[LDC_IDX_TP][LDC_POS_GATE +: 2];
        next_st.div   = {regs[LDC_IDX_DH],
                         regs[LDC_IDX_SY][LDC_DIV_LO_W-1:0]};
        next_st.lock  = regs[LDC_IDX_SY][LDC_POS_LOCK];
        next_st.osc   = !pll_enable;
        // slow divider while the PLL is on and locking to frame sync
        next_st.slow  = pll_enable && regs[LDC_IDX_SY][LDC_POS_LOCK];

        next_st.fs_gated = frame_sync_in && regs[LDC_IDX_SY][LDC_POS_SYNC_EN];
        next_st.fs_prev  = st.fs_gated;
        next_st.crst = regs[LDC_IDX_SY][LDC_POS_CRST]
                       && st.fs_gated && !st.fs_prev;

        // comparator must hold for the filter count
        if (!headroom_cmp) begin
            next_st.filt_cnt  = 9'h000;
            next_st.cmp_valid = 1'b0;
        end else if (pwm_tick && !st.cmp_valid) begin
            next_st.filt_cnt = st.filt_cnt + 9'h001;
            if (st.filt_cnt + 9'h001 >=
                filt_len(regs[LDC_IDX_GF][LDC_POS_HI_NIB-1:0])) begin
                next_st.cmp_valid = 1'b1;
            end
        end

        if (!st.ss_done) begin
            next_st.ss_cnt = st.ss_cnt + 32'h1;
            if (st.ss_cnt + 32'h1 >=
                ss_len(regs[LDC_IDX_TP][LDC_POS_SOFT +: 2])) begin
                next_st.ss_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign prdata                      = st.prdata;
    assign pready                      = st.pready;
    assign pslverr                     = st.pslverr;
    assign sink_four_current_trim      = st.trim4;
    assign sink_three_current_trim     = st.trim3;
    assign temp_sensor_dim_gain        = st.gain;
    assign temp_current_dim_enable     = st.tdim;
    assign powerline_switch_n_type     = st.ntype;
    assign powerline_current_limit_sel = st.limit;
    assign powerline_gate_current_sel  = st.gate;
    assign soft_start_done             = st.ss_done;
    assign slow_divider                = st.div;
    assign frame_sync_gated            = st.fs_gated;
    assign pwm_lock_enable             = st.lock;
    assign pwm_counter_restart         = st.crst;
    assign pwm_clk_from_osc            = st.osc;
    assign use_slow_divider            = st.slow;
    assign headroom_cmp_valid          = st.cmp_valid;

endmodule

/* File: testbench/ldc_chk.sv */
module ldc_chk
    import ldc_pkg::*;
(
    // Clock, reset and APB
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [LDC_ADDR_W-1:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic        pready,
    // Fields and status
    input  wire logic [3:0]  sink_four_current_trim,
    input  wire logic [3:0]  sink_three_current_trim,
    input  wire logic [3:0]  temp_sensor_dim_gain,
    input  wire logic [1:0]  powerline_current_limit_sel,
    input  wire logic [1:0]  powerline_gate_current_sel,
    input  wire logic [12:0] slow_divider,
    input  wire logic        frame_sync_in,
    input  wire logic        frame_sync_gated,
    input  wire logic        pwm_counter_restart,
    input  wire logic        pll_enable,
    input  wire logic        pwm_clk_from_osc,
    input  wire logic        headroom_cmp,
    input  wire logic        headroom_cmp_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Write completes at the access edge
    wire logic wr = ce & psel & penable & pwrite & (paddr[1:0] == 2'b00);
    wire logic [7:0] widx = paddr[LDC_ADDR_W-1:2];

    a_trim_four: assert property (wr && widx == LDC_OFF_TRIM
        |-> ##2 sink_four_current_trim == $past(pwdata[7:4], 2))
        else $error("sink four trim copy wrong");
    a_trim_three: assert property (wr && widx == LDC_OFF_TRIM
        |-> ##2 sink_three_current_trim == $past(pwdata[3:0], 2))
        else $error("sink three trim copy wrong");
    a_gain_copy: assert property (wr && widx == LDC_OFF_GAINFILT
        |-> ##2 temp_sensor_dim_gain == $past(pwdata[7:4], 2))
        else $error("dimming gain copy wrong");
    a_limit_copy: assert property (wr && widx == LDC_OFF_TEMPPL
        |-> ##2 powerline_current_limit_sel == $past(pwdata[3:2], 2))
        else $error("current limit copy wrong");
    a_gate_copy: assert property (wr && widx == LDC_OFF_TEMPPL
        |-> ##2 powerline_gate_current_sel == $past(pwdata[1:0], 2))
        else $error("gate current copy wrong");
    a_div_high: assert property (wr && widx == LDC_OFF_DIVHI
        |-> ##2 slow_divider[12:5] == $past(pwdata[7:0], 2))
        else $error("divider upper bits wrong");
    a_div_low: assert property (wr && widx == LDC_OFF_SYNC
        |-> ##2 slow_divider[4:0] == $past(pwdata[4:0], 2))
        else $error("divider lower bits wrong");
    a_access_ready: assert property (ce && psel && penable |-> pready)
        else $error("no ready in access cycle");
    a_sync_gate: assert property ($past(rst_n) && !$past(frame_sync_in)
        |-> !frame_sync_gated)
        else $error("gated sync without input");
    a_restart_edge: assert property (pwm_counter_restart
        |-> $past(frame_sync_gated) && !$past(frame_sync_gated, 2))
        else $error("restart pulse without sync edge");
    a_osc_follow: assert property ($past(rst_n) && $past(ce)
        |-> pwm_clk_from_osc == !$past(pll_enable))
        else $error("oscillator select wrong");
    a_cmp_clear: assert property (!headroom_cmp |=> !headroom_cmp_valid)
        else $error("comparator valid not cleared");

    c_restart: cover property (pwm_counter_restart);
    c_cmp_valid: cover property (headroom_cmp_valid);
    c_sync_write: cover property (wr && widx == LDC_OFF_SYNC);
endmodule

bind ldc_config_bank ldc_chk u_chk (.*);

/* File: testbench/tb.sv */
module tb
    import ldc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
    logic        frame_sync_in, pll_enable, pwm_tick, headroom_cmp;
    logic        temp_current_dim_enable, powerline_switch_n_type;
    logic        soft_start_done, frame_sync_gated, pwm_lock_enable;
    logic        pwm_counter_restart, pwm_clk_from_osc, use_slow_divider;
    logic        headroom_cmp_valid, er;
    logic [LDC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, d, rd;
    logic [3:0]  sink_four_current_trim, sink_three_current_trim;
    logic [3:0]  temp_sensor_dim_gain;
    logic [1:0]  powerline_current_limit_sel, powerline_gate_current_sel;
    logic [12:0] slow_divider;
    logic [7:0]  mdl [5] = '{LDC_RST_TRIM, LDC_RST_GAINFILT, LDC_RST_TEMPPL,
                             LDC_RST_DIVHI, LDC_RST_SYNC};
    int          i, c, miscompares, compares;
    int          seed = 32'hf1826d0a;
    wire logic [31:0] fld = {sink_four_current_trim, sink_three_current_trim,
        temp_sensor_dim_gain, temp_current_dim_enable, powerline_switch_n_type,
        powerline_current_limit_sel, powerline_gate_current_sel, slow_divider,
        pwm_lock_enable};

    ldc_config_bank dut (.*);

    function automatic logic [31:0] fexp();
        return {mdl[0], mdl[1][7:4], mdl[2][7:6], mdl[2][3:0], mdl[3],
                mdl[4][4:0], mdl[4][6]};
    endfunction

    function automatic int flen(input int k);
        if (k < 4) return 5 << k;
        if (k < 7) return 60 + 20 * (k - 4);
        return 140 + 40 * (k - 7);
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [LDC_ADDR_W-1:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk) pwm_tick <= 1'b1;
            @(posedge clk) pwm_tick <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask

    task automatic results();
        if (miscompares == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {frame_sync_in, pll_enable, pwm_tick, headroom_cmp} = '0;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            apb(1'b0, {LDC_OFF_TRIM + i[7:0], 2'b00}, '0);
            chk(rd, {24'h0, mdl[i]});
        end
        chk(fld, fexp());
        for (i = 0; i < 24; i++) begin
            c = $unsigned($random(seed)) % 5;
            d = $random(seed);
            pll_enable <= d[31];
            apb(1'b1, {LDC_OFF_TRIM + c[7:0], 2'b00}, d);
            mdl[c] = d[7:0];
            apb(1'b0, {LDC_OFF_TRIM + c[7:0], 2'b00}, '0);
            chk(rd, {24'h0, mdl[c]});
            chk(fld, fexp());
            chk({pwm_clk_from_osc, use_slow_divider},
                {~d[31], d[31] & mdl[4][6]});
        end
        // Unmapped place must refuse and leave the bank alone
        apb(1'b1, {LDC_OFF_SYNC, 2'b01}, 32'hff);
        chk(er, 1'b1);
        apb(1'b1, 10'h1c0, 32'hff);
        apb(1'b0, 10'h1c0, '0);
        chk(rd, '0);
        chk(er, 1'b1);
        chk(fld, fexp());
        for (i = 0; i < 2; i++) begin
            apb(1'b1, {LDC_OFF_SYNC, 2'b00}, {24'h0, i[0], 1'b0, i[0], 5'h0});
            @(posedge clk) frame_sync_in <= 1'b1;
            repeat (2) @(negedge clk);
            chk({frame_sync_gated, pwm_counter_restart}, {i[0], 1'b0});
            @(negedge clk);
            chk(pwm_counter_restart, i[0]);
            @(posedge clk) frame_sync_in <= 1'b0;
        end
        // Clock enable low must hold the gated sync flop
        @(posedge clk);
        ce <= 1'b0;
        frame_sync_in <= 1'b1;
        repeat (3) @(posedge clk);
        chk(frame_sync_gated, 1'b0);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk(frame_sync_gated, 1'b1);
        frame_sync_in <= 1'b0;
        for (i = 0; i < 2; i++) begin
            c = i ? $unsigned($random(seed)) % 16 : 0;
            apb(1'b1, {LDC_OFF_GAINFILT, 2'b00}, {28'h0, c[3:0]});
            headroom_cmp <= 1'b1;
            tick(flen(c) - 1);
            chk(headroom_cmp_valid, 1'b0);
            tick(1);
            chk(headroom_cmp_valid, 1'b1);
            headroom_cmp <= 1'b0;
            repeat (2) @(posedge clk);
            chk(headroom_cmp_valid, 1'b0);
        end
        // Whole run is far shorter than the shortest soft start
        chk(soft_start_done, 1'b0);
        results();
    end
endmodule
